//--- verilog/par_regs.sv
// Contract
// - writing one to an interrupt-disable bit clears that event's enable, and reading returns the enables.
// - a read-only field holds the index 0..15 of the key of the last successful resolution, reset zero.
// - a two-bit enable field turns the resolver off at 0 and on at 3, reset off.
// - the key-count register holds 1..16 keys, resets to one, and only that many keys are tried.
// - a pointer register gives the key table from which keys are fetched.
// - a pointer register gives the resolvable address, which is read from there.
// - a pointer register gives scratch memory the resolver writes, which software leaves alone during a run.
// - a run takes about one microsecond plus a fixed time per key tried.
// - writing one to an interrupt-enable-set bit enables that event's interrupt, sharing state with disable.
// - the start task begins a resolution and the stop task halts one in progress.
// - a run raises done on completion, match-found when resolved and no-match when not.
`timescale 1ns/1ps
`default_nettype none

module par_regs
   import par_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [11:0]  wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   output logic              mem_req,
   output logic              mem_we,
   output logic      [31:0]  mem_addr,
   output logic      [31:0]  mem_wdata,
   input  wire logic         mem_ack,
   input  wire logic [31:0]  mem_rdata,
   output logic              cipher_req,
   output logic      [127:0] cipher_key,
   output logic      [23:0]  cipher_prand,
   input  wire logic         cipher_ack,
   input  wire logic [23:0]  cipher_hash,
   output logic              busy,
   output logic              irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // out-of-range counts are clamped so the engine never loops past the table
   function automatic logic [4:0] clamp_count(input logic [7:0] v);
      if (v < 8'(KEY_COUNT_MIN))
         return KEY_COUNT_MIN;
      else if (v > 8'(KEY_COUNT_MAX))
         return KEY_COUNT_MAX;
      else
         return v[4:0];
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic              req;
   logic              wr;
   logic              ack_q;
   logic              ack_d;
   logic [31:0]       rdat_q;
   logic [31:0]       rdat_d;
   logic [1:0]        enable_q;
   logic [1:0]        enable_d;
   logic [4:0]        count_q;
   logic [4:0]        count_d;
   logic [31:0]       key_ptr_q;
   logic [31:0]       key_ptr_d;
   logic [31:0]       addr_ptr_q;
   logic [31:0]       addr_ptr_d;
   logic [31:0]       scr_ptr_q;
   logic [31:0]       scr_ptr_d;
   logic [3:0]        last_q;
   logic [3:0]        last_d;
   logic [NUM_EV-1:0] ev_set;
   logic [NUM_EV-1:0] ev_clr;
   logic [NUM_EV-1:0] en_set;
   logic [NUM_EV-1:0] en_clr;
   logic [NUM_EV-1:0] ev_flags;
   logic [NUM_EV-1:0] ev_enable;
   logic              start_hit;
   logic              stop_hit;
   logic              unit_on;
   par_state_t        st_q;
   par_state_t        st_d;
   logic [3:0]        idx_q;
   logic [3:0]        idx_d;
   logic [1:0]        wcnt_q;
   logic [1:0]        wcnt_d;
   logic [15:0]       pace_q;
   logic [15:0]       pace_d;
   logic              hit_q;
   logic              hit_d;
   logic [23:0]       hash_q;
   logic [23:0]       hash_d;
   logic [23:0]       prand_q;
   logic [23:0]       prand_d;
   logic [127:0]      key_q;
   logic [127:0]      key_d;
   logic              mwe_q;
   logic              mwe_d;
   logic [31:0]       maddr_q;
   logic [31:0]       maddr_d;
   logic [31:0]       mwdata_q;
   logic [31:0]       mwdata_d;

   // ------------------------------------------------------------
   // wishbone slave
   // ------------------------------------------------------------
   // one wait state: ack rises the cycle after the request, drops the next
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr  = req && wb_we_i;

   always_comb
   begin
      ack_d  = req;
      rdat_d = rdat_q;
      if (req)
      begin
         unique case (wb_adr_i)
            OFS_EV_END      : rdat_d = {31'h0, ev_flags[EV_END]};
            OFS_EV_MATCH    : rdat_d = {31'h0, ev_flags[EV_MATCH]};
            OFS_EV_NOMATCH  : rdat_d = {31'h0, ev_flags[EV_NOMATCH]};
            OFS_INTEN_SET,
            OFS_INTEN_CLR   : rdat_d = {29'h0, ev_enable};
            OFS_LAST_MATCH  : rdat_d = {28'h0, last_q};
            OFS_ENABLE      : rdat_d = {30'h0, enable_q};
            OFS_KEY_COUNT   : rdat_d = {27'h0, count_q};
            OFS_KEY_PTR     : rdat_d = key_ptr_q;
            OFS_ADDR_PTR    : rdat_d = addr_ptr_q;
            OFS_SCRATCH_PTR : rdat_d = scr_ptr_q;
            default         : rdat_d = 32'h0000_0000;                              // tasks and holes read zero
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   assign start_hit = wr && wb_adr_i == OFS_START && wb_sel_i[0] && wb_dat_i[0];
   assign stop_hit  = wr && wb_adr_i == OFS_STOP && wb_sel_i[0] && wb_dat_i[0];
   assign unit_on   = enable_q == ENABLE_ON;

   always_comb
   begin
      enable_d   = enable_q;
      count_d    = count_q;
      key_ptr_d  = key_ptr_q;
      addr_ptr_d = addr_ptr_q;
      scr_ptr_d  = scr_ptr_q;
      en_set     = '0;
      en_clr     = '0;
      ev_clr     = '0;
      if (wr)
      begin
         unique case (wb_adr_i)
            OFS_ENABLE      : if (wb_sel_i[0]) enable_d = wb_dat_i[1:0];
            OFS_KEY_COUNT   : if (wb_sel_i[0]) count_d = clamp_count(wb_dat_i[7:0]);
            OFS_KEY_PTR     : key_ptr_d  = merge(key_ptr_q, wb_dat_i, wb_sel_i);
            OFS_ADDR_PTR    : addr_ptr_d = merge(addr_ptr_q, wb_dat_i, wb_sel_i);
            OFS_SCRATCH_PTR : scr_ptr_d  = merge(scr_ptr_q, wb_dat_i, wb_sel_i);
            OFS_INTEN_SET   : if (wb_sel_i[0]) en_set = wb_dat_i[NUM_EV-1:0];
            OFS_INTEN_CLR   : if (wb_sel_i[0]) en_clr = wb_dat_i[NUM_EV-1:0];
            OFS_EV_END      : ev_clr[EV_END]     = wb_sel_i[0] & wb_dat_i[0];
            OFS_EV_MATCH    : ev_clr[EV_MATCH]   = wb_sel_i[0] & wb_dat_i[0];
            OFS_EV_NOMATCH  : ev_clr[EV_NOMATCH] = wb_sel_i[0] & wb_dat_i[0];
            default         : ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         enable_q   <= ENABLE_OFF;
         count_q    <= KEY_COUNT_RST;
         key_ptr_q  <= PTR_RST;
         addr_ptr_q <= PTR_RST;
         scr_ptr_q  <= PTR_RST;
      end
      else
      begin
         enable_q   <= enable_d;
         count_q    <= count_d;
         key_ptr_q  <= key_ptr_d;
         addr_ptr_q <= addr_ptr_d;
         scr_ptr_q  <= scr_ptr_d;
      end
   end

   // ------------------------------------------------------------
   // resolver engine
   // ------------------------------------------------------------
   // run paced so it never beats the overhead plus per-key budget
   always_comb
   begin
      st_d     = st_q;
      idx_d    = idx_q;
      wcnt_d   = wcnt_q;
      pace_d   = (pace_q != 16'h0) ? pace_q - 16'h1 : pace_q;
      hit_d    = hit_q;
      hash_d   = hash_q;
      prand_d  = prand_q;
      key_d    = key_q;
      mwe_d    = mwe_q;
      maddr_d  = maddr_q;
      mwdata_d = mwdata_q;
      last_d   = last_q;
      ev_set   = '0;
      unique case (st_q)
         ST_IDLE :
            if (start_hit && unit_on)
            begin
               st_d    = ST_ADDR0;
               idx_d   = 4'h0;
               hit_d   = 1'b0;
               pace_d  = OVH_CYC + PER_KEY_CYC;
               mwe_d   = 1'b0;
               maddr_d = addr_ptr_q;
            end
         ST_ADDR0 :
            if (mem_ack)
            begin
               hash_d        = mem_rdata[23:0];
               prand_d[7:0]  = mem_rdata[31:24];
               st_d          = ST_ADDR1;
               maddr_d       = addr_ptr_q + 32'h4;
            end
         ST_ADDR1 :
            if (mem_ack)
            begin
               prand_d[23:8] = mem_rdata[15:0];
               st_d          = ST_SCR;
               mwe_d         = 1'b1;
               maddr_d       = scr_ptr_q;
               mwdata_d      = {8'h00, mem_rdata[15:0], prand_q[7:0]};
            end
         ST_SCR :
            if (mem_ack)
            begin
               st_d    = ST_KEY;
               wcnt_d  = 2'h0;
               mwe_d   = 1'b0;
               maddr_d = key_ptr_q + {24'h0, idx_q, 4'h0};
            end
         ST_KEY :
            if (mem_ack)
            begin
               key_d[wcnt_q*32 +: 32] = mem_rdata;
               wcnt_d  = wcnt_q + 2'h1;
               maddr_d = maddr_q + 32'h4;
               if (wcnt_q == KEY_WORDS_LAST)
                  st_d = ST_CIPH;
            end
         ST_CIPH :
            if (cipher_ack)
            begin
               hit_d = cipher_hash == hash_q;
               st_d  = ST_PACE;
            end
         ST_PACE :
            if (pace_q == 16'h0)
            begin
               if (hit_q)
               begin
                  last_d               = idx_q;
                  ev_set[EV_MATCH]     = 1'b1;
                  ev_set[EV_END]       = 1'b1;
                  st_d                 = ST_IDLE;
               end
               else if ({1'b0, idx_q} + 5'h1 >= count_q)
               begin
                  ev_set[EV_NOMATCH]   = 1'b1;
                  ev_set[EV_END]       = 1'b1;
                  st_d                 = ST_IDLE;
               end
               else
               begin
                  idx_d   = idx_q + 4'h1;
                  wcnt_d  = 2'h0;
                  pace_d  = PER_KEY_CYC;
                  maddr_d = key_ptr_q + {24'h0, idx_q + 4'h1, 4'h0};
                  st_d    = ST_KEY;
               end
            end
      endcase
      // stop or disable abandons the run quietly; a late memory ack is ignored
      if (st_q != ST_IDLE && (stop_hit || !unit_on))
      begin
         st_d   = ST_IDLE;
         ev_set = '0;
         last_d = last_q;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q     <= ST_IDLE;
         idx_q    <= 4'h0;
         wcnt_q   <= 2'h0;
         pace_q   <= 16'h0;
         hit_q    <= 1'b0;
         hash_q   <= 24'h0;
         prand_q  <= 24'h0;
         key_q    <= 128'h0;
         mwe_q    <= 1'b0;
         maddr_q  <= 32'h0;
         mwdata_q <= 32'h0;
         last_q   <= LAST_MATCH_RST;
      end
      else
      begin
         st_q     <= st_d;
         idx_q    <= idx_d;
         wcnt_q   <= wcnt_d;
         pace_q   <= pace_d;
         hit_q    <= hit_d;
         hash_q   <= hash_d;
         prand_q  <= prand_d;
         key_q    <= key_d;
         mwe_q    <= mwe_d;
         maddr_q  <= maddr_d;
         mwdata_q <= mwdata_d;
         last_q   <= last_d;
      end
   end

   // memory and cipher handshakes follow the state directly
   assign mem_req      = st_q == ST_ADDR0 || st_q == ST_ADDR1 || st_q == ST_SCR || st_q == ST_KEY;
   assign mem_we       = mwe_q;
   assign mem_addr     = maddr_q;
   assign mem_wdata    = mwdata_q;
   assign cipher_req   = st_q == ST_CIPH;
   assign cipher_key   = key_q;
   assign cipher_prand = prand_q;
   assign busy         = st_q != ST_IDLE;

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   par_evt u_evt
   (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .ev_set    (ev_set),
      .ev_clr    (ev_clr),
      .en_set    (en_set),
      .en_clr    (en_clr),
      .ev_flags  (ev_flags),
      .ev_enable (ev_enable),
      .irq       (irq)
   );

endmodule

`default_nettype wire

//--- include/par_pkg.sv
package par_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_START       = 12'h000;
   localparam logic [11:0] OFS_STOP        = 12'h008;
   localparam logic [11:0] OFS_EV_END      = 12'h100;
   localparam logic [11:0] OFS_EV_MATCH    = 12'h104;
   localparam logic [11:0] OFS_EV_NOMATCH  = 12'h108;
   localparam logic [11:0] OFS_INTEN_SET   = 12'h304;
   localparam logic [11:0] OFS_INTEN_CLR   = 12'h308;
   localparam logic [11:0] OFS_LAST_MATCH  = 12'h400;
   localparam logic [11:0] OFS_ENABLE      = 12'h500;
   localparam logic [11:0] OFS_KEY_COUNT   = 12'h504;
   localparam logic [11:0] OFS_KEY_PTR     = 12'h508;
   localparam logic [11:0] OFS_ADDR_PTR    = 12'h510;
   localparam logic [11:0] OFS_SCRATCH_PTR = 12'h514;

   // ------------------------------------------------------------
   // field layouts and reset values
   // ------------------------------------------------------------
   localparam int          NUM_EV          = 3;
   localparam int          EV_END          = 0;
   localparam int          EV_MATCH        = 1;
   localparam int          EV_NOMATCH      = 2;
   localparam logic [1:0]  ENABLE_OFF      = 2'h0;
   localparam logic [1:0]  ENABLE_ON       = 2'h3;
   localparam logic [4:0]  KEY_COUNT_RST   = 5'h01;
   localparam logic [4:0]  KEY_COUNT_MIN   = 5'h01;
   localparam logic [4:0]  KEY_COUNT_MAX   = 5'h10;
   localparam logic [3:0]  LAST_MATCH_RST  = 4'h0;
   localparam logic [31:0] PTR_RST         = 32'h0000_0000;
   localparam logic [1:0]  KEY_WORDS_LAST  = 2'h3;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_PS   = 8000;
   localparam int          OVERHEAD_NS     = 1000;
   localparam int          RUN8_US         = 48;
   localparam int          RUN8_KEYS       = 8;
   localparam int          PER_KEY_NS      = (RUN8_US * 1000 - OVERHEAD_NS) / RUN8_KEYS;
   localparam logic [15:0] OVH_CYC         = 16'(OVERHEAD_NS * 1000 / CLK_PERIOD_PS);
   localparam logic [15:0] PER_KEY_CYC     = 16'(PER_KEY_NS * 1000 / CLK_PERIOD_PS);

   // ------------------------------------------------------------
   // resolver states
   // ------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b000_0001,
      ST_ADDR0 = 7'b000_0010,
      ST_ADDR1 = 7'b000_0100,
      ST_SCR   = 7'b000_1000,
      ST_KEY   = 7'b001_0000,
      ST_CIPH  = 7'b010_0000,
      ST_PACE  = 7'b100_0000
   } par_state_t;

endpackage

//--- verilog/par_evt.sv
`timescale 1ns/1ps
`default_nettype none

module par_evt
   import par_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              resetn,
   input  wire logic [NUM_EV-1:0] ev_set,
   input  wire logic [NUM_EV-1:0] ev_clr,
   input  wire logic [NUM_EV-1:0] en_set,
   input  wire logic [NUM_EV-1:0] en_clr,
   output logic      [NUM_EV-1:0] ev_flags,
   output logic      [NUM_EV-1:0] ev_enable,
   output logic                   irq
);

   logic [NUM_EV-1:0] ev_q;
   logic [NUM_EV-1:0] ev_d;
   logic [NUM_EV-1:0] en_q;
   logic [NUM_EV-1:0] en_d;
   logic              irq_q;
   logic              irq_d;

   // ------------------------------------------------------------
   // sticky flags and shared enable state
   // ------------------------------------------------------------
   // a set in the same cycle as a clear wins, so no event is lost
   always_comb
   begin
      ev_d  = (ev_q & ~ev_clr) | ev_set;
      en_d  = (en_q | en_set) & ~en_clr;
      irq_d = |(ev_d & en_d);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ev_q  <= '0;
         en_q  <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         ev_q  <= ev_d;
         en_q  <= en_d;
         irq_q <= irq_d;
      end
   end

   assign ev_flags  = ev_q;
   assign ev_enable = en_q;
   assign irq       = irq_q;

endmodule

`default_nettype wire

//--- verif/par_checker.sv
`timescale 1ns/1ps
`default_nettype none

module par_checker
   import par_pkg::*;
(
   input wire logic         core_clk,
   input wire logic         resetn,
   input wire logic         wb_cyc_i,
   input wire logic         wb_stb_i,
   input wire logic         wb_we_i,
   input wire logic [11:0]  wb_adr_i,
   input wire logic [31:0]  wb_dat_o,
   input wire logic         wb_ack_o,
   input wire logic         mem_req,
   input wire logic         mem_we,
   input wire logic [31:0]  mem_addr,
   input wire logic         mem_ack,
   input wire logic         cipher_req,
   input wire logic [127:0] cipher_key,
   input wire logic         cipher_ack,
   input wire logic         busy,
   input wire logic         irq
);
   logic rd_req;
   logic wr_req;

   // a request counts only while ack is low, the way the slave takes it
   assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_ack_next;
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not acked next cycle");
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
   property p_count_range;
      (rd_req && wb_adr_i == OFS_KEY_COUNT) |=> (wb_dat_o >= 32'h1 && wb_dat_o <= 32'h10);
   endproperty
   a_count_range: assert property (p_count_range) else $error("key count out of range");
   property p_index_range;
      (rd_req && wb_adr_i == OFS_LAST_MATCH) |=> wb_dat_o[31:4] == 28'h0;
   endproperty
   a_index_range: assert property (p_index_range) else $error("match index too wide");
   // memory and cipher stay quiet outside a run
   property p_idle_quiet;
      !busy |-> !mem_req && !cipher_req;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("traffic while idle");
   // a bus write may abort a run, so it releases the hold
   property p_mem_hold;
      (mem_req && !mem_ack && !wr_req) |=> mem_req && $stable(mem_addr) && $stable(mem_we);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request moved before ack");
   property p_cipher_hold;
      (cipher_req && !cipher_ack && !wr_req) |=> cipher_req && $stable(cipher_key);
   endproperty
   a_cipher_hold: assert property (p_cipher_hold) else $error("cipher request moved before ack");
   property p_scratch;
      (mem_req && mem_we) |-> busy;
   endproperty
   a_scratch: assert property (p_scratch) else $error("scratch write outside a run");
   property p_irq_rise;
      $rose(irq) |-> $past(busy) || $past(wr_req);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
   property p_irq_fall;
      $fell(irq) |-> $past(wr_req);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
endmodule

bind par_regs par_checker par_checker_i (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .mem_req, .mem_we, .mem_addr, .mem_ack, .cipher_req, .cipher_key, .cipher_ack,
   .busy, .irq);

`default_nettype wire

//--- verif/par_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module par_mem_model
   import par_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         resetn,
   input  wire logic         mem_req,
   input  wire logic         mem_we,
   input  wire logic [31:0]  mem_addr,
   input  wire logic [31:0]  mem_wdata,
   output logic              mem_ack,
   output logic      [31:0]  mem_rdata,
   input  wire logic         cipher_req,
   input  wire logic [127:0] cipher_key,
   output logic              cipher_ack,
   output logic      [23:0]  cipher_hash
);
   logic [31:0] mem [0:255];  // loaded by the bench only
   int          lat;          // wait cycles before each answer
   int          cnt;
   int          n_rd;
   logic [31:0] last_rd;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;

   // memory answers after lat cycles; released data is inverted so it never looks valid
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         cnt <= 0;
         n_rd <= 0;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack && cnt >= lat)
         begin
            mem_ack <= 1'b1;
            cnt <= 0;
            if (mem_we)
            begin
               wr_addr <= mem_addr;
               wr_data <= mem_wdata;
            end
            else
            begin
               mem_rdata <= mem[mem_addr[9:2]];
               n_rd <= n_rd + 1;
               last_rd <= mem_addr;
            end
         end
         else if (mem_req && !mem_ack)
            cnt <= cnt + 1;
      end
   end

   // stand-in hash: low bits of the first key word
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cipher_ack <= 1'b0;
         cipher_hash <= 24'h0;
      end
      else
      begin
         cipher_ack <= cipher_req && !cipher_ack;
         cipher_hash <= (cipher_req && !cipher_ack) ? cipher_key[23:0] : ~cipher_hash;
      end
   end
endmodule

`default_nettype wire

//--- verif/par_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module par_regs_tb
   import par_pkg::*;
;
   logic          core_clk = 1'b0;
   logic          resetn = 1'b0;
   logic          wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0]   wb_adr_i = 12'h000;
   logic [3:0]    wb_sel_i = 4'hf;
   logic [31:0]   wb_dat_i = 32'h0, wb_dat_o, mem_addr, mem_wdata, mem_rdata;
   logic          wb_ack_o, mem_req, mem_we, mem_ack, cipher_req, cipher_ack, busy, irq;
   logic [127:0]  cipher_key;
   logic [23:0]   cipher_prand, cipher_hash;
   logic [31:0]   rv;
   int            n_errors = 0, n_checks = 0, n_cyc = 0, n0;
   logic [11:0]   rst_adr [8] = '{OFS_ENABLE, OFS_KEY_COUNT, OFS_LAST_MATCH, OFS_INTEN_SET,
                                  OFS_INTEN_CLR, OFS_KEY_PTR, OFS_EV_END, 12'h0fc};

   par_regs par_regs_i (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .cipher_req,
      .cipher_key, .cipher_prand, .cipher_ack, .cipher_hash, .busy, .irq);
   par_mem_model par_mem_model_i (.core_clk, .resetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
      .mem_rdata, .cipher_req, .cipher_key, .cipher_ack, .cipher_hash);

   always #4 core_clk = ~core_clk;

   // hang guard, well above the longest sixteen-key run
   always @(posedge core_clk)
   begin
      n_cyc++;
      if (n_cyc == 40000)
      begin
         n_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one classic cycle; ack and read data are taken at the same rising edge
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
         @(posedge core_clk);
      while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      wb(1'b1, a, d, rv);
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0, rv);
      check($sformatf("reg %h", a), rv, exp);
   endtask

   task automatic run(input int n);
      int t;
      int lo;
      t = 0;
      lo = 125 + 734 * n;
      wr(OFS_START, 32'h1);
      check("busy on", 32'(busy), 32'h1);
      while (busy === 1'b1)
      begin
         @(negedge core_clk);
         t++;
      end
      check("run cycles", 32'(t + 1 >= lo && t <= lo + 30), 32'h1);
   endtask

   initial
   begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      foreach (rst_adr[i]) rc(rst_adr[i], (i == 1) ? 32'h1 : 32'h0);
      wr(OFS_KEY_COUNT, 32'h0);
      rc(OFS_KEY_COUNT, 32'h1);
      wr(OFS_KEY_COUNT, 32'h1f);
      rc(OFS_KEY_COUNT, 32'h10);
      wr(OFS_KEY_PTR, 32'h100);
      wr(OFS_ADDR_PTR, 32'h300);
      wr(OFS_SCRATCH_PTR, 32'h308);
      rc(OFS_KEY_PTR, 32'h100);
      rc(OFS_ADDR_PTR, 32'h300);
      rc(OFS_SCRATCH_PTR, 32'h308);
      // a disabled unit ignores start
      wr(OFS_START, 32'h1);
      repeat (3) @(posedge core_clk);
      check("busy off", 32'(busy), 32'h0);
      wr(OFS_INTEN_SET, 32'h7);
      rc(OFS_INTEN_CLR, 32'h7);
      wr(OFS_INTEN_CLR, 32'h1);
      rc(OFS_INTEN_SET, 32'h6);
      // three keys, address matches key 2, slow memory
      for (int k = 0; k < 256; k++) par_mem_model_i.mem[k] = 32'(k);
      par_mem_model_i.mem[192] = 32'hff00_0048;
      par_mem_model_i.mem[193] = 32'h0000_beef;
      par_mem_model_i.lat = 3;
      wr(OFS_ENABLE, 32'h3);
      rc(OFS_ENABLE, 32'h3);
      wr(OFS_KEY_COUNT, 32'h3);
      n0 = par_mem_model_i.n_rd;
      run(3);
      rc(OFS_LAST_MATCH, 32'h2);
      rc(OFS_EV_END, 32'h1);
      rc(OFS_EV_MATCH, 32'h1);
      rc(OFS_EV_NOMATCH, 32'h0);
      check("irq match", 32'(irq), 32'h1);
      check("reads", 32'(par_mem_model_i.n_rd - n0), 32'd14);
      check("last read", par_mem_model_i.last_rd, 32'h12c);
      check("scratch addr", par_mem_model_i.wr_addr, 32'h308);
      check("scratch data", {8'h0, par_mem_model_i.wr_data[23:0]}, 32'h00be_efff);
      check("prand", 32'(cipher_prand), 32'h00be_efff);
      wr(OFS_INTEN_CLR, 32'h2);
      check("irq masked", 32'(irq), 32'h0);
      wr(OFS_EV_MATCH, 32'h1);
      rc(OFS_EV_MATCH, 32'h0);
      // all sixteen keys, no match, prompt memory
      par_mem_model_i.mem[192] = 32'h00ff_ffff;
      par_mem_model_i.lat = 0;
      wr(OFS_KEY_COUNT, 32'h10);
      n0 = par_mem_model_i.n_rd;
      run(16);
      rc(OFS_EV_NOMATCH, 32'h1);
      rc(OFS_LAST_MATCH, 32'h2);
      check("irq nomatch", 32'(irq), 32'h1);
      check("reads", 32'(par_mem_model_i.n_rd - n0), 32'd66);
      check("last read", par_mem_model_i.last_rd, 32'h1fc);
      wr(OFS_EV_END, 32'h1);
      wr(OFS_EV_NOMATCH, 32'h1);
      check("irq cleared", 32'(irq), 32'h0);
      // stop halts a run with no events
      wr(OFS_START, 32'h1);
      repeat (40) @(posedge core_clk);
      wr(OFS_STOP, 32'h1);
      repeat (3) @(posedge core_clk);
      check("busy stopped", 32'(busy), 32'h0);
      rc(OFS_EV_END, 32'h0);
      rc(OFS_EV_NOMATCH, 32'h0);
      // one byte lane only reaches the pointer
      wb_sel_i <= 4'h2;
      wr(OFS_SCRATCH_PTR, 32'hffff_ffff);
      rc(OFS_SCRATCH_PTR, 32'h0000_ff08);
      finish_test();
   end
endmodule

`default_nettype wire
